// ==== hw/bzo_pkg.sv ====
`default_nettype none
package bzo_pkg;
    // register byte addresses on the wishbone bus
    localparam logic [15:0] CLK_SEL_ADDR  = 16'hff40;
    localparam logic [15:0] P3_DIR_ADDR   = 16'hff44;
    localparam logic [15:0] P3_LATCH_ADDR = 16'hff48;
    // field positions in the clock select register
    localparam int          OUT_EN_BIT    = 7;
    localparam int          FSEL_LO_BIT   = 5;
    localparam int          FSEL_HI_BIT   = 6;
    localparam logic [7:0]  CLK_SEL_MASK  = 8'he0;
    // reset values
    localparam logic [7:0]  CLK_SEL_RST   = 8'h00;
    localparam logic [7:0]  P3_DIR_RST    = 8'hff;
    localparam logic [7:0]  P3_LATCH_RST  = 8'h00;
    // tone pin sits on port 3 bit 3
    localparam int          TONE_PIN_BIT  = 3;
    // smallest divide exponent; code 00 gives 2^10
    localparam int          DIV_EXP_BASE  = 10;
    localparam int          DIV_W         = 13;
endpackage : bzo_pkg
`default_nettype wire

// ==== hw/bzo_top.sv ====
// Behaviour
// - tone frequency is clock over 2^10, 2^11, 2^12, 2^13 for codes 00..11
// - enable low stops divider and holds tone pin low while latch bit 3 is 0
// - enable lives at bit 7; writing 1 starts the tone
// - reset clears clock select register to 00
// - clock select accepts byte writes only; bit operations arrive as read-modify-write bytes
// - direction bit 0 drives pin as output, 1 makes it input
// - reset sets all port 3 direction bits to 1
// - direction register writable per byte only, no per-bit write path
`timescale 1ns/10ps
`default_nettype none
module bzo_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [15:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    output logic             err_o,
    // port 3 pins
    input  wire logic [7:0]  port3_pin_i,
    output logic      [7:0]  port3_pin_o,
    output logic      [7:0]  port3_pin_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    // divider width; top bit is headroom beyond the slowest half period
    localparam int    DIV_W = bzo_pkg::DIV_W;
    logic [7:0]       buzzer_clock_select_reg;
    logic [7:0]       port3_direction_reg;
    logic [7:0]       port3_latch_reg;
    logic [7:0]       pin_meta_reg;
    logic [7:0]       pin_sync_reg;
    logic [DIV_W-1:0] div_cnt_reg;
    logic             tone_pin_reg;
    logic             req;
    logic             hit_cks;
    logic             hit_dir;
    logic             hit_lat;
    logic             wr_lane0;
    logic [1:0]       fsel;
    logic             buzzer_out_enable;
    logic             half_tick;

    // decode; only lane 0 carries data, sel_i[0] gates every write
    assign req      = cyc_i && stb_i && !ack_o && !err_o;
    assign hit_cks  = adr_i == bzo_pkg::CLK_SEL_ADDR;
    assign hit_dir  = adr_i == bzo_pkg::P3_DIR_ADDR;
    assign hit_lat  = adr_i == bzo_pkg::P3_LATCH_ADDR;
    assign wr_lane0 = req && we_i && sel_i[0];
    assign buzzer_out_enable = buzzer_clock_select_reg[bzo_pkg::OUT_EN_BIT];
    assign fsel = {buzzer_clock_select_reg[bzo_pkg::FSEL_HI_BIT],
                   buzzer_clock_select_reg[bzo_pkg::FSEL_LO_BIT]};

    ////////////////////////////////////////////////////////////////////////
    // bus answer: one cycle ack, err on unmapped address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req && (hit_cks || hit_dir || hit_lat);
            err_o <= req && !(hit_cks || hit_dir || hit_lat);
            if (req && !we_i) begin
                unique case (1'b1)
                    hit_cks: dat_o <= {24'h00_0000, buzzer_clock_select_reg};
                    hit_dir: dat_o <= {24'h00_0000, port3_direction_reg};
                    hit_lat: dat_o <= {24'h00_0000, port3_latch_reg};
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // clock select; byte write stores bits 7..5 only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buzzer_clock_select_reg <= bzo_pkg::CLK_SEL_RST;
        end else if (wr_lane0 && hit_cks) begin
            // bit ops arrive as read-modify-write bytes
            buzzer_clock_select_reg <= dat_i[7:0] & bzo_pkg::CLK_SEL_MASK;
        end
    end

    // port 3 direction, resets to all inputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port3_direction_reg <= bzo_pkg::P3_DIR_RST;
        end else if (wr_lane0 && hit_dir) begin
            port3_direction_reg <= dat_i[7:0];
        end
    end

    // port 3 output latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port3_latch_reg <= bzo_pkg::P3_LATCH_RST;
        end else if (wr_lane0 && hit_lat) begin
            port3_latch_reg <= dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // half period is 2^(9+code) cycles, so full period 2^(10+code)
    always_comb begin
        unique case (fsel)
            2'b00: half_tick = &div_cnt_reg[8:0];
            2'b01: half_tick = &div_cnt_reg[9:0];
            2'b10: half_tick = &div_cnt_reg[10:0];
            2'b11: half_tick = &div_cnt_reg[11:0];
        endcase
    end

    // divider runs only while enabled; cleared so restart is clean
    always_ff @(posedge clk_i) begin
        if (rst_i || !buzzer_out_enable) begin
            div_cnt_reg  <= '0;
            tone_pin_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_reg + DIV_W'(1);             // wraps freely
            if (half_tick) begin
                tone_pin_reg <= !tone_pin_reg;
            end
        end
    end

    // pin drive: tone ORed onto latch for pin 3 (latch must be 0)
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port3_pin_o    <= 8'h00;
            port3_pin_oe_o <= 8'h00;
        end else begin
            port3_pin_o    <= port3_latch_reg;
            port3_pin_o[bzo_pkg::TONE_PIN_BIT] <=
                port3_latch_reg[bzo_pkg::TONE_PIN_BIT] | tone_pin_reg;
            port3_pin_oe_o <= ~port3_direction_reg;
        end
    end

    // pin inputs synchronised; reserved for port reads
    always_ff @(posedge clk_i) begin
        pin_meta_reg <= port3_pin_i;
        pin_sync_reg <= pin_meta_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // tone generation checks
    a_tone_low_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !buzzer_out_enable |=> !tone_pin_reg)
        else $error("tone not low while disabled");
    a_div_halted: assert property (@(posedge clk_i) disable iff (rst_i)
        !buzzer_out_enable |=> div_cnt_reg == {DIV_W{1'b0}})
        else $error("divider ran while disabled");
    a_cks_low_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        buzzer_clock_select_reg[4:0] == 5'h00)
        else $error("reserved select bits not zero");
    a_toggle_code0: assert property (@(posedge clk_i) disable iff (rst_i)
        (buzzer_out_enable && fsel == 2'b00 && div_cnt_reg[8:0] == 9'h1ff)
        |=> $changed(tone_pin_reg))
        else $error("tone did not toggle at half period");
    a_toggle_code3: assert property (@(posedge clk_i) disable iff (rst_i)
        (buzzer_out_enable && fsel == 2'b11 && div_cnt_reg[11:0] == 12'hfff)
        |=> $changed(tone_pin_reg))
        else $error("tone did not toggle at slowest half period");
    a_no_early_tog: assert property (@(posedge clk_i) disable iff (rst_i)
        (buzzer_out_enable && $past(buzzer_out_enable) && $changed(tone_pin_reg))
        |-> $past(half_tick))
        else $error("tone toggled off half period");
    a_enable_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && hit_cks && dat_i[7]) |=> buzzer_out_enable)
        else $error("enable write did not start tone");

    // pin drive checks; the tone only reaches the pin with latch bit 3 clear
    a_tone_on_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> port3_pin_o[bzo_pkg::TONE_PIN_BIT] ==
            ($past(port3_latch_reg[bzo_pkg::TONE_PIN_BIT]) | $past(tone_pin_reg)))
        else $error("tone pin drive wrong");
    a_dir_oe_map: assert property (@(posedge clk_i) disable iff (rst_i)
        $stable(port3_direction_reg)
        |=> port3_pin_oe_o == ~$past(port3_direction_reg))
        else $error("output enable not inverse of direction");
    a_pin_reset: assert property (@(posedge clk_i)
        rst_i |=> (port3_pin_oe_o == 8'h00 && port3_pin_o == 8'h00))
        else $error("pins driven during reset");

    // register checks
    a_cks_reset: assert property (@(posedge clk_i)
        rst_i |=> buzzer_clock_select_reg == 8'h00)
        else $error("select register not cleared by reset");
    a_dir_reset: assert property (@(posedge clk_i)
        rst_i |=> port3_direction_reg == 8'hff)
        else $error("direction register not set by reset");
    a_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && hit_dir) |=> port3_direction_reg == $past(dat_i[7:0]))
        else $error("direction write lost");
    a_lat_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_lane0 && hit_lat) |=> port3_latch_reg == $past(dat_i[7:0]))
        else $error("latch write lost");
    a_sel_masked: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && we_i && !sel_i[0])
        |=> ($stable(buzzer_clock_select_reg) && $stable(port3_direction_reg)))
        else $error("write without lane 0 changed a register");
    a_read_select: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !we_i && hit_cks) |=> dat_o == {24'h00_0000, $past(buzzer_clock_select_reg)})
        else $error("select read data wrong");

    // bus answer checks; one answer per request, never both kinds
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    a_ack_mapped: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && (hit_cks || hit_dir || hit_lat)) |=> (ack_o && !err_o))
        else $error("mapped access not acknowledged");
    a_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !(hit_cks || hit_dir || hit_lat)) |=> (err_o && !ack_o))
        else $error("unmapped access not refused");

endmodule : bzo_top
`default_nettype wire

// ==== verification/bzo_buzzer.sv ====
`timescale 1ns/10ps
`default_nettype none
// buzzer on the pin: counts cycles between pin changes
module bzo_buzzer (
    // clock and pin
    input  wire logic        clk_i,
    input  wire logic        pin_i,
    // measured half period and change count
    output logic      [15:0] half_o,
    output logic      [7:0]  edges_o
);
    logic        prev_reg  = 1'b0;
    logic [15:0] cnt_reg   = 16'h0000;
    logic [15:0] half_reg  = 16'h0000;
    logic [7:0]  edges_reg = 8'h00;
    assign half_o  = half_reg;
    assign edges_o = edges_reg;
    // a pin change closes one half period
    always @(posedge clk_i) begin
        prev_reg <= pin_i;
        if (pin_i != prev_reg) begin
            cnt_reg   <= 16'h0001;
            half_reg  <= cnt_reg;
            edges_reg <= edges_reg + 8'h01;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule // bzo_buzzer
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [15:0] adr_i = 16'h0000, half;
    logic [31:0] dat_i = 32'h0, dat_o, rd, d, seed = 32'h26f4;
    logic        ack_o, err_o, got_err;
    logic [3:0]  sel_i = 4'hf, wsel = 4'hf;
    logic [7:0]  pin_o, oe, ext = 8'h00, edges, e0, code;
    wire  [7:0]  pins = (oe & pin_o) | (~oe & ext); // undriven pins follow the board
    int          num_errors = 0, samples_checked = 0, cyc_n = 0;
    initial forever #2.5 clk_i = ~clk_i;
    bzo_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .port3_pin_i(pins), .port3_pin_o(pin_o), .port3_pin_oe_o(oe));
    bzo_buzzer bz (.clk_i(clk_i), .pin_i(pins[3]), .half_o(half), .edges_o(edges));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // select register keeps bits 7..5, the rest reads zero
    function automatic logic [31:0] exp_sel(input logic [7:0] v);
        return {24'h00_0000, v & bzo_pkg::CLK_SEL_MASK};
    endfunction
    // half period in cycles for frequency code c
    function automatic logic [31:0] exp_half(input int c);
        return 32'h1 << (bzo_pkg::DIV_EXP_BASE - 1 + c);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("errors=%0d checks=%0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one classic cycle; held until ack or err is sampled high
    task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] v);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= {24'h0, v};
        sel_i <= wsel;
        do @(posedge clk_i); while (!(ack_o === 1'b1 || err_o === 1'b1));
        rd = dat_o;
        got_err = err_o;
        cyc_i <= 1'b0; stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // hang guard, run needs about 32000 cycles
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 60000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, bzo_pkg::CLK_SEL_ADDR, 8'h00); chk(rd, 32'h00);
        wb(1'b0, bzo_pkg::P3_DIR_ADDR, 8'h00); chk(rd, 32'hff);
        chk(32'(oe), 32'h00);
        // random bytes, enable kept low while the code moves
        repeat (6) begin
            d = next_rand();
            ext <= d[15:8];
            wb(1'b1, bzo_pkg::CLK_SEL_ADDR, d[7:0] & 8'h7f);
            wb(1'b0, bzo_pkg::CLK_SEL_ADDR, 8'h00); chk(rd, exp_sel(d[7:0] & 8'h7f));
            wb(1'b1, bzo_pkg::P3_DIR_ADDR, d[23:16]);
            wb(1'b0, bzo_pkg::P3_DIR_ADDR, 8'h00); chk(rd, 32'(d[23:16]));
            chk(32'(oe), {24'h00_0000, ~d[23:16]});
        end
        // a write without lane 0 is acknowledged and ignored
        wsel = 4'he;
        wb(1'b1, bzo_pkg::CLK_SEL_ADDR, ~d[7:0] & 8'h7f);
        wsel = 4'hf;
        wb(1'b0, bzo_pkg::CLK_SEL_ADDR, 8'h00); chk(rd, exp_sel(d[7:0] & 8'h7f));
        wb(1'b0, 16'h0000, 8'h00); chk(32'(got_err), 32'h1);
        // per-pin setup: only the tone pin becomes an output
        wb(1'b1, bzo_pkg::P3_DIR_ADDR, 8'hff);
        wb(1'b1, bzo_pkg::P3_DIR_ADDR, 8'hf7);
        wb(1'b1, bzo_pkg::P3_LATCH_ADDR, 8'h00);
        chk(32'(oe), 32'h08);
        for (int c = 0; c < 4; c++) begin
            code = 8'(c) << 5;
            wb(1'b1, bzo_pkg::CLK_SEL_ADDR, code);
            repeat (20) @(posedge clk_i);
            chk(32'(pin_o[3]), 32'h0);
            e0 = edges;
            wb(1'b1, bzo_pkg::CLK_SEL_ADDR, 8'h80 | code);
            while (edges != e0 + 8'h03) @(posedge clk_i);
            chk(32'(half), exp_half(c));
            while (edges != e0 + 8'h04) @(posedge clk_i);
            chk(32'(half), exp_half(c));
            wb(1'b1, bzo_pkg::CLK_SEL_ADDR, code);
            wb(1'b0, bzo_pkg::CLK_SEL_ADDR, 8'h00); chk(rd, exp_sel(code));
            repeat (3) @(posedge clk_i);
            e0 = edges;
            repeat (100) @(posedge clk_i);
            chk({pin_o[3], edges}, {1'b0, e0});
        end
        // reset in mid-tone drops the pin and restores both registers
        wb(1'b1, bzo_pkg::CLK_SEL_ADDR, 8'h00);
        wb(1'b1, bzo_pkg::CLK_SEL_ADDR, 8'h80);
        e0 = edges;
        while (edges == e0) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({oe, pin_o}, 16'h0000);
        wb(1'b0, bzo_pkg::CLK_SEL_ADDR, 8'h00); chk(rd, 32'h00);
        wb(1'b0, bzo_pkg::P3_DIR_ADDR, 8'h00); chk(rd, 32'hff);
        results();
    end
endmodule // testbench
`default_nettype wire
